/* verilog/async_sync_conv_pkg.sv */
`default_nettype none
package async_sync_conv_pkg;

  // register map (byte addresses)
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;

  // control register fields
  localparam int          CTRL_SB_POS   = 0;
  localparam int          CTRL_WL_POS   = 1;
  localparam int          CTRL_RATE_POS = 2;
  localparam int          CTRL_CM_POS   = 5;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;

  // pin synchroniser reset: async input idles high
  localparam logic [5:0]  PIN_RESET     = 6'h01;

  // reference clock and rate steps (32 x bit rate per reference edge)
  localparam logic [22:0] REF_HZ        = 23'h3e8000;
  localparam logic [22:0] STEP_38400    = 23'h12c000;
  localparam logic [22:0] STEP_19200    = 23'h096000;
  localparam logic [22:0] STEP_9600     = 23'h04b000;
  localparam logic [22:0] STEP_4800     = 23'h025800;
  localparam logic [22:0] STEP_2400     = 23'h012c00;
  localparam logic [22:0] STEP_1200     = 23'h009600;
  localparam logic [22:0] STEP_300      = 23'h002580;

  // character timing in 16x ticks
  localparam logic [3:0]  TICK_LAST     = 4'hf;
  localparam logic [3:0]  TICK_SHORT    = 4'he;
  localparam logic [3:0]  TICK_MID      = 4'h7;

  // synchronous patterns, sent lsb first
  localparam logic [7:0]  FLAG_PATTERN  = 8'h7e;
  localparam logic [7:0]  BREAK_PATTERN = 8'h7f;
  localparam logic [3:0]  PATTERN_LEFT  = 4'h7;
  localparam logic [2:0]  STUFF_RUN     = 3'h5;
  localparam logic [2:0]  FLAG_RUN      = 3'h6;
  localparam logic [2:0]  RUN_MAX       = 3'h7;
  localparam logic [6:0]  FLAG_INTERVAL = 7'h3c;
  localparam logic [3:0]  MODE1_BITS    = 4'h8;
  localparam logic [2:0]  TX_LEVEL_MIN  = 3'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } char_state_t;

  typedef struct packed {
    logic       cm;
    logic [2:0] rate;
    logic       wl;
    logic       sb;
  } ctrl_t;

  typedef struct packed {
    logic [2:0] rx_count;
    logic [2:0] tx_count;
    logic       rx_break;
    logic       tx_break;
    logic       rx_status;
    logic       tx_level;
  } status_t;

  function automatic logic [22:0] rate_step(input logic [2:0] sel);
    case (sel)
      3'h1:    rate_step = STEP_38400;
      3'h2:    rate_step = STEP_19200;
      3'h3:    rate_step = STEP_9600;
      3'h4:    rate_step = STEP_4800;
      3'h5:    rate_step = STEP_2400;
      3'h6:    rate_step = STEP_1200;
      3'h7:    rate_step = STEP_300;
      default: rate_step = 23'h000000;
    endcase
  endfunction

endpackage
`default_nettype wire

/* verilog/async_sync_data_converter.sv */
`timescale 1ns/100ps
`default_nettype none
module async_sync_data_converter #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        async_tx_i,
  output logic             async_rx_o,
  input  wire logic        rate_clock_in_i,
  output logic             sampling_clock_out_o,
  input  wire logic        sync_bit_clock_i,
  input  wire logic        sync_in_enable_i,
  input  wire logic        sync_out_enable_i,
  input  wire logic        sync_data_in_i,
  output logic             sync_data_out_o,
  output logic             sync_data_oe_o,
  output logic             tx_fifo_level_flag_o,
  output logic             rx_sync_status_o
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(FIFO_DEPTH);

  // pins {data in, out enable, in enable, bit clock, rate clock, async}
  logic [5:0] meta_ff, pin_ff, prev_ff;
  async_sync_conv_pkg::ctrl_t ctrl_ff;
  logic                       ack_ff;
  logic [31:0]                rdat_ff;
  async_sync_conv_pkg::status_t status;
  logic txd, rclk, dc, sync_in_enable, sync_out_enable, sync_data_in, p_dc, p_die, p_doe;
  assign txd  = pin_ff[0];
  assign rclk = pin_ff[1];
  assign dc   = pin_ff[2];
  assign sync_in_enable  = pin_ff[3];
  assign sync_out_enable  = pin_ff[4];
  assign sync_data_in  = pin_ff[5];
  assign p_dc  = prev_ff[2];
  assign p_die = prev_ff[3];
  assign p_doe = prev_ff[4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= async_sync_conv_pkg::PIN_RESET;
      pin_ff  <= async_sync_conv_pkg::PIN_RESET;
      prev_ff <= async_sync_conv_pkg::PIN_RESET;
    end else begin
      meta_ff <= {sync_data_in_i, sync_out_enable_i, sync_in_enable_i,
                  sync_bit_clock_i, rate_clock_in_i, async_tx_i};
      pin_ff  <= meta_ff;
      prev_ff <= pin_ff;
    end
  end

  // wishbone slave, one wait state, unmapped reads zero
  logic wb_req;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= wb_req;
      rdat_ff <= 32'h00000000;
      if (wb_req && !wb_we_i && wb_adr_i == async_sync_conv_pkg::CTRL_OFFSET)
        rdat_ff <= {26'h0000000, ctrl_ff};
      if (wb_req && !wb_we_i &&
          wb_adr_i == async_sync_conv_pkg::STATUS_OFFSET)
        rdat_ff <= {22'h000000, status};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ctrl_ff <= async_sync_conv_pkg::CTRL_RESET;
    else if (wb_req && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == async_sync_conv_pkg::CTRL_OFFSET)
      ctrl_ff <= wb_dat_i[5:0];
  end

  logic [3:0] len_m1;
  assign len_m1 = ctrl_ff.wl ? 4'h8 : 4'h7;

  // 16x clock: direct rate clock or fractional divide of reference
  logic [22:0] acc_ff, acc_sum;
  logic        so_ff, so_prev_ff, tick16, rclk_rise;
  assign rclk_rise = rclk & ~prev_ff[1];
  assign acc_sum   = acc_ff + async_sync_conv_pkg::rate_step(ctrl_ff.rate);
  assign tick16    = so_ff & ~so_prev_ff;
  assign sampling_clock_out_o = so_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff     <= 23'h000000;
      so_ff      <= 1'b0;
      so_prev_ff <= 1'b0;
    end else begin
      so_prev_ff <= so_ff;
      if (ctrl_ff.rate == 3'h0) begin
        so_ff  <= rclk;
        acc_ff <= 23'h000000;
      end else if (rclk_rise) begin
        if (acc_sum >= async_sync_conv_pkg::REF_HZ) begin
          acc_ff <= acc_sum - async_sync_conv_pkg::REF_HZ;
          so_ff  <= ~so_ff;
        end else begin
          acc_ff <= acc_sum;
        end
      end
    end
  end

  // async stripper
  async_sync_conv_pkg::char_state_t st_ff;
  logic [3:0] st_tick_ff, st_bit_ff;
  logic [8:0] st_word_ff;
  logic       brk_ff, tx_push;
  logic [8:0] tx_wdata;
  assign tx_wdata = ctrl_ff.wl ? st_word_ff : {1'b0, st_word_ff[8:1]};
  assign tx_push  = tick16 && st_ff == async_sync_conv_pkg::ST_STOP &&
                    st_tick_ff == async_sync_conv_pkg::TICK_LAST && txd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff      <= async_sync_conv_pkg::ST_IDLE;
      st_tick_ff <= 4'h0;
      st_bit_ff  <= 4'h0;
      st_word_ff <= 9'h000;
      brk_ff     <= 1'b0;
    end else if (tick16) begin
      st_tick_ff <= st_tick_ff + 4'h1;
      case (st_ff)
        async_sync_conv_pkg::ST_IDLE: begin
          if (txd)
            brk_ff <= 1'b0;
          if (!txd && !brk_ff) begin
            st_ff      <= async_sync_conv_pkg::ST_START;
            st_tick_ff <= 4'h0;
          end
        end
        async_sync_conv_pkg::ST_START: begin
          if (st_tick_ff == async_sync_conv_pkg::TICK_MID) begin
            st_ff      <= txd ? async_sync_conv_pkg::ST_IDLE
                              : async_sync_conv_pkg::ST_DATA;
            st_tick_ff <= 4'h0;
            st_bit_ff  <= 4'h0;
          end
        end
        async_sync_conv_pkg::ST_DATA: begin
          if (st_tick_ff == async_sync_conv_pkg::TICK_LAST) begin
            st_word_ff <= {txd, st_word_ff[8:1]};
            st_bit_ff  <= st_bit_ff + 4'h1;
            if (st_bit_ff == len_m1)
              st_ff <= async_sync_conv_pkg::ST_STOP;
          end
        end
        async_sync_conv_pkg::ST_STOP: begin
          if (st_tick_ff == async_sync_conv_pkg::TICK_LAST) begin
            st_ff <= async_sync_conv_pkg::ST_IDLE;
            if (!txd && st_word_ff == 9'h000)
              brk_ff <= 1'b1;
          end
        end
        default: st_ff <= async_sync_conv_pkg::ST_IDLE;
      endcase
    end
  end

  // transmit fifo
  logic [8:0]  tx_mem [FIFO_DEPTH];
  logic [AW-1:0] tx_wr_ff, tx_rd_ff;
  logic [AW:0] tx_cnt_ff;
  logic        tx_pop, tx_empty, tx_lvl_ff;
  assign tx_empty = tx_cnt_ff == '0;

  always_ff @(posedge clk_i) begin
    if (tx_push && tx_cnt_ff != FULL)
      tx_mem[tx_wr_ff] <= tx_wdata;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_wr_ff  <= '0;
      tx_rd_ff  <= '0;
      tx_cnt_ff <= '0;
      tx_lvl_ff <= 1'b0;
    end else begin
      if (tx_push && tx_cnt_ff != FULL)
        tx_wr_ff <= tx_wr_ff + 1'b1;
      if (tx_pop)
        tx_rd_ff <= tx_rd_ff + 1'b1;
      tx_cnt_ff <= tx_cnt_ff + (AW+1)'(tx_push && tx_cnt_ff != FULL)
                             - (AW+1)'(tx_pop);
      tx_lvl_ff <= tx_cnt_ff < (AW+1)'(async_sync_conv_pkg::TX_LEVEL_MIN);
    end
  end
  assign tx_fifo_level_flag_o = tx_lvl_ff;

  // synchronous transmitter
  logic       tx_strobe, tx_strobe_p, advance;
  logic [3:0] mode1_cnt_ff, tx_left_ff;
  logic [8:0] tx_sr_ff;
  logic       tx_bit_ff, tx_kind_ff;
  logic [2:0] tx_ones_ff;
  logic [6:0] tx_since_ff;
  logic       stuff_now, load_now, send_flag;
  assign tx_strobe   = ctrl_ff.cm ? (dc & sync_out_enable) : ~(dc & sync_out_enable);
  assign tx_strobe_p = ctrl_ff.cm ? (p_dc & p_doe) : ~(p_dc & p_doe);
  assign advance     = tx_strobe & ~tx_strobe_p &
                       (~ctrl_ff.cm | mode1_cnt_ff < async_sync_conv_pkg::MODE1_BITS);
  assign stuff_now   = tx_kind_ff && tx_ones_ff == async_sync_conv_pkg::STUFF_RUN;
  assign load_now    = advance && !stuff_now && tx_left_ff == 4'h0;
  assign send_flag   = tx_since_ff == async_sync_conv_pkg::FLAG_INTERVAL ||
                       (tx_empty && !brk_ff);
  assign tx_pop      = load_now && !send_flag && !tx_empty;

  always_ff @(posedge clk_i) begin
    if (rst_i || !sync_out_enable)
      mode1_cnt_ff <= 4'h0;
    else if (advance)
      mode1_cnt_ff <= mode1_cnt_ff + 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bit_ff   <= 1'b1;
      tx_sr_ff    <= 9'h000;
      tx_left_ff  <= 4'h0;
      tx_kind_ff  <= 1'b0;
      tx_ones_ff  <= 3'h0;
      tx_since_ff <= 7'h00;
    end else if (advance) begin
      if (stuff_now) begin
        tx_bit_ff  <= 1'b0;
        tx_ones_ff <= 3'h0;
      end else if (load_now) begin
        tx_ones_ff <= 3'h0;
        if (send_flag || tx_empty) begin
          tx_kind_ff <= 1'b0;
          tx_left_ff <= async_sync_conv_pkg::PATTERN_LEFT;
          if (send_flag) begin
            tx_bit_ff   <= async_sync_conv_pkg::FLAG_PATTERN[0];
            tx_sr_ff    <= {2'b00, async_sync_conv_pkg::FLAG_PATTERN[7:1]};
            tx_since_ff <= 7'h00;
          end else begin
            tx_bit_ff <= async_sync_conv_pkg::BREAK_PATTERN[0];
            tx_sr_ff  <= {2'b00, async_sync_conv_pkg::BREAK_PATTERN[7:1]};
          end
        end else begin
          tx_kind_ff  <= 1'b1;
          tx_left_ff  <= len_m1;
          tx_bit_ff   <= tx_mem[tx_rd_ff][0];
          tx_sr_ff    <= {1'b0, tx_mem[tx_rd_ff][8:1]};
          tx_ones_ff  <= tx_mem[tx_rd_ff][0] ? tx_ones_ff + 3'h1 : 3'h0;
          tx_since_ff <= tx_since_ff + 7'h01;
        end
      end else begin
        tx_bit_ff  <= tx_sr_ff[0];
        tx_sr_ff   <= {1'b0, tx_sr_ff[8:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        if (tx_kind_ff)
          tx_ones_ff <= tx_sr_ff[0] ? tx_ones_ff + 3'h1 : 3'h0;
      end
    end
  end
  assign sync_data_out_o = tx_bit_ff;
  assign sync_data_oe_o  = sync_out_enable & ~rst_i;

  // synchronous receiver
  logic       rx_strobe, rx_strobe_p, sample;
  logic [2:0] rx_run_ff;
  logic [3:0] rx_cnt_ff;
  logic [8:0] rx_word_ff;
  logic       hunt_ff, lost_ff, rbrk_ff, ovr_ff, rx_stat_ff;
  logic [6:0] rx_since_ff;
  logic       rx_push, rx_pop, rx_full, rx_empty;
  logic [8:0] rx_wdata;
  assign rx_strobe   = ctrl_ff.cm ? (dc & sync_in_enable) : ~(~dc & sync_in_enable);
  assign rx_strobe_p = ctrl_ff.cm ? (p_dc & p_die) : ~(~p_dc & p_die);
  assign sample      = ~rx_strobe & rx_strobe_p;
  assign rx_wdata    = ctrl_ff.wl ? {sync_data_in, rx_word_ff[8:1]}
                                  : {1'b0, sync_data_in, rx_word_ff[8:2]};
  assign rx_push     = sample && sync_data_in && rx_cnt_ff == len_m1 && !hunt_ff ||
                       sample && !sync_data_in && rx_run_ff < async_sync_conv_pkg::STUFF_RUN &&
                       rx_cnt_ff == len_m1 && !hunt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_run_ff   <= 3'h0;
      rx_cnt_ff   <= 4'h0;
      rx_word_ff  <= 9'h000;
      hunt_ff     <= 1'b1;
      lost_ff     <= 1'b0;
      rbrk_ff     <= 1'b0;
      rx_since_ff <= 7'h00;
    end else if (sample) begin
      if (!sync_data_in && rx_run_ff == async_sync_conv_pkg::STUFF_RUN) begin
        rx_run_ff <= 3'h0;
      end else if (!sync_data_in && rx_run_ff == async_sync_conv_pkg::FLAG_RUN) begin
        rx_run_ff   <= 3'h0;
        rx_cnt_ff   <= 4'h0;
        hunt_ff     <= 1'b0;
        lost_ff     <= 1'b0;
        rbrk_ff     <= 1'b0;
        rx_since_ff <= 7'h00;
      end else if (!sync_data_in && rx_run_ff == async_sync_conv_pkg::RUN_MAX) begin
        rx_run_ff <= 3'h0;
        rx_cnt_ff <= 4'h0;
        rbrk_ff   <= 1'b1;
      end else begin
        if (sync_data_in && rx_run_ff != async_sync_conv_pkg::RUN_MAX)
          rx_run_ff <= rx_run_ff + 3'h1;
        else if (!sync_data_in)
          rx_run_ff <= 3'h0;
        rx_word_ff <= {sync_data_in, rx_word_ff[8:1]};
        rx_cnt_ff  <= rx_cnt_ff + 4'h1;
        if (rx_cnt_ff == len_m1) begin
          rx_cnt_ff <= 4'h0;
          if (!hunt_ff) begin
            rbrk_ff     <= 1'b0;
            rx_since_ff <= rx_since_ff + 7'h01;
            if (rx_since_ff == async_sync_conv_pkg::FLAG_INTERVAL)
              lost_ff <= 1'b1;
          end
        end
      end
    end
  end

  // receive fifo, newest word overwrites the last word written when full
  logic [8:0]    rx_mem [FIFO_DEPTH];
  logic [AW-1:0] rx_wr_ff, rx_rd_ff;
  logic [AW:0]   rx_cnt_q_ff;
  logic          rx_over;
  assign rx_full  = rx_cnt_q_ff == FULL;
  assign rx_empty = rx_cnt_q_ff == '0;
  assign rx_over  = rx_push && rx_full && !rx_pop;

  always_ff @(posedge clk_i) begin
    if (rx_over)
      rx_mem[rx_wr_ff - 1'b1] <= rx_wdata;
    else if (rx_push)
      rx_mem[rx_wr_ff] <= rx_wdata;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_wr_ff    <= '0;
      rx_rd_ff    <= '0;
      rx_cnt_q_ff <= '0;
    end else begin
      if (rx_push && !rx_over)
        rx_wr_ff <= rx_wr_ff + 1'b1;
      if (rx_pop)
        rx_rd_ff <= rx_rd_ff + 1'b1;
      rx_cnt_q_ff <= rx_cnt_q_ff + (AW+1)'(rx_push && !rx_over)
                                 - (AW+1)'(rx_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ovr_ff <= 1'b0;
    else if (rx_over)
      ovr_ff <= 1'b1;
    else if (p_dc && !dc)
      ovr_ff <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      rx_stat_ff <= 1'b0;
    else
      rx_stat_ff <= ~hunt_ff & ~lost_ff & ~ovr_ff;
  end
  assign rx_sync_status_o = rx_stat_ff;

  // data formatter
  async_sync_conv_pkg::char_state_t fm_ff;
  logic [3:0] fm_tick_ff, fm_bit_ff, fm_limit;
  logic [8:0] fm_word_ff;
  logic       fm_out_ff, fm_stops_ff, fm_short_ff;
  assign rx_pop   = tick16 && fm_ff == async_sync_conv_pkg::ST_IDLE && !rx_empty;
  assign fm_limit = (fm_short_ff && !rx_empty && !fm_stops_ff) ?
                    async_sync_conv_pkg::TICK_SHORT :
                    async_sync_conv_pkg::TICK_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fm_ff       <= async_sync_conv_pkg::ST_IDLE;
      fm_tick_ff  <= 4'h0;
      fm_bit_ff   <= 4'h0;
      fm_word_ff  <= 9'h000;
      fm_out_ff   <= 1'b1;
      fm_stops_ff <= 1'b0;
      fm_short_ff <= 1'b0;
    end else if (tick16) begin
      fm_tick_ff <= fm_tick_ff + 4'h1;
      case (fm_ff)
        async_sync_conv_pkg::ST_IDLE: begin
          fm_tick_ff <= 4'h0;
          fm_out_ff  <= ~rbrk_ff;
          if (!rx_empty) begin
            fm_word_ff <= rx_mem[rx_rd_ff];
            fm_out_ff  <= 1'b0;
            fm_ff      <= async_sync_conv_pkg::ST_START;
          end
        end
        async_sync_conv_pkg::ST_START: begin
          if (fm_tick_ff == async_sync_conv_pkg::TICK_LAST) begin
            fm_out_ff <= fm_word_ff[0];
            fm_bit_ff <= 4'h0;
            fm_ff     <= async_sync_conv_pkg::ST_DATA;
          end
        end
        async_sync_conv_pkg::ST_DATA: begin
          if (fm_tick_ff == async_sync_conv_pkg::TICK_LAST) begin
            fm_bit_ff  <= fm_bit_ff + 4'h1;
            fm_word_ff <= {1'b0, fm_word_ff[8:1]};
            fm_out_ff  <= fm_word_ff[1];
            if (fm_bit_ff == len_m1) begin
              fm_out_ff   <= 1'b1;
              fm_stops_ff <= ctrl_ff.sb;
              fm_ff       <= async_sync_conv_pkg::ST_STOP;
            end
          end
        end
        async_sync_conv_pkg::ST_STOP: begin
          if (fm_tick_ff == fm_limit) begin
            fm_tick_ff <= 4'h0;
            if (fm_stops_ff) begin
              fm_stops_ff <= 1'b0;
            end else begin
              if (!rx_empty)
                fm_short_ff <= ~fm_short_ff;
              fm_ff <= async_sync_conv_pkg::ST_IDLE;
            end
          end
        end
        default: fm_ff <= async_sync_conv_pkg::ST_IDLE;
      endcase
    end
  end
  assign async_rx_o = fm_out_ff;

  assign status.rx_count  = 3'(rx_cnt_q_ff);
  assign status.tx_count  = 3'(tx_cnt_ff);
  assign status.rx_break  = rbrk_ff;
  assign status.tx_break  = brk_ff;
  assign status.rx_status = rx_stat_ff;
  assign status.tx_level  = tx_lvl_ff;

endmodule
`default_nettype wire

/* tb/async_sync_conv_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module async_sync_conv_checker #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        sync_out_enable_i,
  input wire logic        sync_data_oe_o,
  input wire logic        async_rx_o,
  input wire logic        sampling_clock_out_o,
  input wire logic        tx_fifo_level_flag_o,
  input wire logic        rx_sync_status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cleared;
    !tx_fifo_level_flag_o && !rx_sync_status_o && async_rx_o
      && !sampling_clock_out_o;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RELEASE: assert property ($fell(rst_i) |-> s_cleared ##1 tx_fifo_level_flag_o)
    else $error("reset state wrong");
  AST_RX_HOLD: assert property ($fell(rst_i) |-> (!rx_sync_status_o && async_rx_o) [*8])
    else $error("receiver left hold early");
  AST_OE_OFF: assert property (!sync_out_enable_i [*4] |-> !sync_data_oe_o)
    else $error("output driven while disabled");
  AST_OE_ON: assert property (sync_out_enable_i [*4] |-> sync_data_oe_o)
    else $error("output not driven while enabled");
endmodule
bind async_sync_data_converter async_sync_conv_checker #(
  .FIFO_DEPTH(FIFO_DEPTH)
) chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .sync_out_enable_i(sync_out_enable_i), .sync_data_oe_o(sync_data_oe_o),
  .async_rx_o(async_rx_o), .sampling_clock_out_o(sampling_clock_out_o),
  .tx_fifo_level_flag_o(tx_fifo_level_flag_o),
  .rx_sync_status_o(rx_sync_status_o)
);
`default_nettype wire

/* tb/sync_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module sync_far_end (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       dout_i,
  output logic            bit_clk_o,
  output logic            out_en_o,
  output logic            in_en_o,
  output logic            din_o,
  output logic [7:0]      seen_o
);
  logic [3:0] phase_ff;
  initial begin
    phase_ff = 4'h0;
    bit_clk_o = 1'b0;
    out_en_o = 1'b0;
    din_o = 1'b1;
    seen_o = 8'h00;
  end
  assign in_en_o = 1'b1;
  // clock pauses only in its low phase, enable moves only then
  always @(posedge clk_i) begin
    if (run_i || phase_ff != 4'h4) phase_ff <= phase_ff + 4'h1;
    bit_clk_o <= phase_ff[3];
    if (phase_ff == 4'h4) out_en_o <= run_i;
    // loop back each bit mid high phase, lsb first
    if (phase_ff == 4'hc) begin
      seen_o <= {dout_i, seen_o[7:1]};
      din_o <= dout_i;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        txd = 1'b1;
  logic        run = 1'b0;
  logic [2:0]  rck = 3'h0;
  logic [31:0] rdat, q;
  logic        ack, rxd, sampling_clock_out, dclk, oen, ien, din, dout, sync_out_enable, lvl, rx_sync_status;
  logic [7:0]  seen;
  logic [8:0]  ch;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  always @(posedge clk) rck <= rck + 3'h1;
  async_sync_data_converter uut (
    .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .async_tx_i(txd), .async_rx_o(rxd),
    .rate_clock_in_i(rck[2]), .sampling_clock_out_o(sampling_clock_out),
    .sync_bit_clock_i(dclk), .sync_in_enable_i(ien),
    .sync_out_enable_i(oen), .sync_data_in_i(din),
    .sync_data_out_o(dout), .sync_data_oe_o(sync_out_enable),
    .tx_fifo_level_flag_o(lvl), .rx_sync_status_o(rx_sync_status)
  );
  sync_far_end far (
    .clk_i(clk), .run_i(run), .dout_i(dout), .bit_clk_o(dclk),
    .out_en_o(oen), .in_en_o(ien), .din_o(din), .seen_o(seen)
  );
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timed_out(input int n, input int lim);
    if (n >= lim) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    timed_out(n, 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // start, eight data bits lsb first, one stop; 128 clocks a bit
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= f[i];
      repeat (128) @(posedge clk);
    end
  endtask
  task automatic rx_char();
    int n;
    for (n = 0; n < 20000 && rxd !== 1'b0; n++) @(posedge clk);
    timed_out(n, 20000);
    repeat (64) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (128) @(posedge clk);
      ch = {rxd, ch[8:1]};
    end
  endtask
  initial begin
    int n;
    int m;
    logic bp;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(4'h4, 1'b0, 32'h0);
    chk(q, 32'h1);
    wb(4'h0, 1'b1, 32'h3f);
    wb(4'h0, 1'b0, 32'h0);
    chk(q, 32'h3f);
    wb(4'h0, 1'b1, 32'h0);
    wb(4'h8, 1'b1, 32'hff);
    wb(4'h8, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    run <= 1'b1;
    for (n = 0; n < 400 && seen !== 8'h7e; n++) @(posedge clk);
    timed_out(n, 400);
    repeat (128) @(posedge clk);
    chk(seen, 8'h7e);
    m = 0;
    bp = sampling_clock_out;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (sampling_clock_out && !bp) m++;
      bp = sampling_clock_out;
    end
    chk(m, 50);
    chk(rx_sync_status, 1'b1);
    $display("test idle flags done");
    fork
      send(8'hf9);
      rx_char();
    join
    chk(ch, 9'h1f9);
    $display("test loopback done");
    run <= 1'b0;
    repeat (64) @(posedge clk);
    send(8'he1);
    send(8'h1f);
    repeat (200) @(posedge clk);
    chk(lvl, 1'b0);
    wb(4'h4, 1'b0, 32'h0);
    chk(q & 32'h71, 32'h20);
    run <= 1'b1;
    rx_char();
    chk(ch, 9'h1e1);
    rx_char();
    chk(ch, 9'h11f);
    chk(lvl, 1'b1);
    $display("test fifo fill done");
    txd <= 1'b0;
    repeat (1800) @(posedge clk);
    chk(rxd, 1'b0);
    wb(4'h4, 1'b0, 32'h0);
    chk(q & 32'he, 32'he);
    txd <= 1'b1;
    repeat (600) @(posedge clk);
    chk(rxd, 1'b1);
    $display("test break done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
